// ===== src/qdac_pkg.sv
// Shared constants, types and decode functions of the quad DAC command core
package qdac_pkg;
   // Channel count and field widths
   localparam int NCH = 4;
   localparam int CODE_W = 16;
   localparam int SPAN_W = 4;
   // Command codes
   localparam logic [3:0] CMD_WR_SPAN = 4'h2;
   localparam logic [3:0] CMD_WR_CODE = 4'h3;
   localparam logic [3:0] CMD_UPD_N = 4'h4;
   localparam logic [3:0] CMD_UPD_ALL = 4'h5;
   localparam logic [3:0] CMD_WU_SPAN_N = 4'h6;
   localparam logic [3:0] CMD_WU_CODE_N = 4'h7;
   localparam logic [3:0] CMD_WU_SPAN_ALL = 4'h8;
   localparam logic [3:0] CMD_WU_CODE_ALL = 4'h9;
   localparam logic [3:0] CMD_RD_HSPAN = 4'ha;
   localparam logic [3:0] CMD_RD_ACODE = 4'hd;
   localparam logic [3:0] CMD_SLEEP = 4'he;
   localparam logic [3:0] CMD_NOP = 4'hf;
   // Channel address codes
   localparam logic [3:0] ADDR_A = 4'h0;
   localparam logic [3:0] ADDR_B = 4'h2;
   localparam logic [3:0] ADDR_C = 4'h4;
   localparam logic [3:0] ADDR_D = 4'h6;
   localparam logic [3:0] ADDR_ALL = 4'hf;
   // Span codes
   localparam logic [3:0] SPAN_U5 = 4'h0;
   localparam logic [3:0] SPAN_U10 = 4'h1;
   localparam logic [3:0] SPAN_B5 = 4'h2;
   localparam logic [3:0] SPAN_B10 = 4'h3;
   localparam logic [3:0] SPAN_B2P5 = 4'h4;
   localparam logic [3:0] SPAN_OFS = 4'h5;
   // Reset values
   localparam logic [15:0] CODE_RST = 16'h0000;
   localparam logic [3:0] SPAN_RST = SPAN_U5;
   // Frame bit counts
   localparam logic [5:0] FRAME_BITS = 6'h18;
   localparam logic [5:0] HDR_BITS = 6'h08;
   localparam logic [5:0] PREFIX_BITS = 6'h08;
   localparam logic [5:0] CNT_MAX = 6'h3f;
   // Readback buffer select, ordered so read command low bits map onto it
   typedef enum logic [1:0] {
      RB_ASPAN, RB_ACODE, RB_HSPAN, RB_HCODE
   } qdac_rbsel_e;
   // Address code is one of the defined set
   function automatic logic qdac_addr_ok(input logic [3:0] a);
      return (a == ADDR_A) || (a == ADDR_B) || (a == ADDR_C) ||
         (a == ADDR_D) || (a == ADDR_ALL);
   endfunction
   // Channel index of an address; all-channels points at channel A
   function automatic logic [1:0] qdac_addr_ch(input logic [3:0] a);
      case (a)
         ADDR_B: return 2'h1;
         ADDR_C: return 2'h2;
         ADDR_D: return 2'h3;
         default: return 2'h0;
      endcase
   endfunction
   // Command is one of the four read commands
   function automatic logic qdac_is_read(input logic [3:0] c);
      return (c >= CMD_RD_HSPAN) && (c <= CMD_RD_ACODE);
   endfunction
   // Buffer chosen by a read command
   function automatic qdac_rbsel_e qdac_rd_sel(input logic [3:0] c);
      return qdac_rbsel_e'(c[1:0]);
   endfunction
endpackage

// ===== src/qdac_sync.sv
// Two flip-flop level synchroniser with a constant reset value
`timescale 1ns/1ps
module qdac_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Destination clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Levels in and out
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   // First stage feeds only the second
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end
   assign dout = sync_ff;
endmodule

// ===== src/qdac_link.sv
// Serial link logic on the serial clock: input shifter and readback shifter
`timescale 1ns/1ps
module qdac_link
   import qdac_pkg::*;
(
   // Link clock, frame and resets
   input wire logic sclk,
   input wire logic select_load_n,
   input wire logic serial_in,
   input wire logic async_clear_n,
   input wire logic sys_rst,
   // Buffers, stable while a frame is open
   input wire logic [63:0] hold_code,
   input wire logic [15:0] hold_span,
   input wire logic [63:0] act_code,
   input wire logic [15:0] act_span,
   input wire logic [3:0] sleep,
   input wire logic [1:0] ptr_sel,
   input wire logic [1:0] ptr_ch,
   // Captured frame, read by the core after the frame closes
   output logic [23:0] frame_bits,
   output logic [5:0] frame_count,
   // Readback pin data
   output logic readback_out
);
   logic hard_rst;
   logic frame_rst;
   logic armed_ff;
   logic pre_ff;
   logic [23:0] sh_ff;
   logic [5:0] cnt_ff;
   logic [15:0] rb_ff;
   logic hdr_read;
   logic hdr_zero;
   logic load_now;
   qdac_rbsel_e sel;
   logic [1:0] ch;
   logic [15:0] word;
   // Clear empties the shifter at once; a high select rearms the start of the next frame
   assign hard_rst = sys_rst | ~async_clear_n;
   assign frame_rst = hard_rst | select_load_n;
   // First edge of a frame restarts the count
   always_ff @(posedge sclk or posedge frame_rst) begin
      if (frame_rst) armed_ff <= 1'b1;
      else armed_ff <= 1'b0;
   end
   // [R1] Shift in MSB first
   always_ff @(posedge sclk or posedge hard_rst) begin
      if (hard_rst) begin
         sh_ff <= '0;
         cnt_ff <= '0;
      end else if (!select_load_n) begin
         sh_ff <= {sh_ff[22:0], serial_in};
         cnt_ff <= armed_ff ? 6'h01 :
            (cnt_ff == CNT_MAX) ? CNT_MAX : cnt_ff + 6'h01;
      end
   end
   // Header decode: a zero command nibble marks the 8-bit zero prefix
   assign hdr_read = qdac_is_read(sh_ff[7:4]);
   assign hdr_zero = (sh_ff[7:4] == 4'h0);
   assign load_now = ((cnt_ff == HDR_BITS) && !hdr_zero) ||
      ((cnt_ff == HDR_BITS + PREFIX_BITS) && pre_ff);
   // [R8] Read commands pick their own buffer; [R9] others use the pointer
   assign sel = hdr_read ? qdac_rd_sel(sh_ff[7:4]) : qdac_rbsel_e'(ptr_sel);
   assign ch = hdr_read ? qdac_addr_ch(sh_ff[3:0]) : ptr_ch;
   // [R22] [R3] Span word carries sleep above the four span bits
   assign word = (sel == RB_HSPAN) ?
         {11'h000, sleep[ch], hold_span[{ch, 2'h0} +: 4]} :
      (sel == RB_ASPAN) ? {11'h000, sleep[ch], act_span[{ch, 2'h0} +: 4]} :
      (sel == RB_HCODE) ? hold_code[{ch, 4'h0} +: 16] :
      act_code[{ch, 4'h0} +: 16];
   // [R2] Low until the header is in, then 16 bits on falling edges
   always_ff @(negedge sclk or posedge frame_rst) begin
      if (frame_rst) begin
         rb_ff <= '0;
         pre_ff <= 1'b0;
      end else begin
         if (cnt_ff == HDR_BITS) pre_ff <= hdr_zero;
         if (load_now) rb_ff <= word;
         else rb_ff <= {rb_ff[14:0], 1'b0};
      end
   end
   assign frame_bits = sh_ff;
   assign frame_count = cnt_ff;
   assign readback_out = rb_ff[15];
endmodule

// ===== src/qdac_core.sv
// Command core of a quad DAC controlled over a serial command link
//
// Function
// [R1] Frame: 4-bit command, 4-bit address, 16 data bits; 32-bit adds zeros
// [R2] Readback low until header in, then 16 bits on falling edges
// [R3] Span sits in the last four data bits, written and read
// [R4] Load pin low while select high updates every channel
// [R5] 0010 writes holding span, 0011 holding code; active untouched
// [R6] 0100 updates addressed channel(s); 0101 updates all channels
// [R7] 0110/0111 write then update channel; 1000/1001 write, update all
// [R8] 1010-1101 read holding/active span/code in the same frame
// [R9] Other commands shift out the buffer the previous command chose
// [R10] Pointer set per command kind for the following frame
// [R11] Addresses 0,2,4,6 pick A-D; 1111 picks all, pointer at A
// [R12] Span codes 0000-0101 select the six output ranges
// [R13] Host sends only defined command, address and span codes
// [R14] Power-up: spans 0000, all buffers zero, outputs zero
// [R15] Clear zeroes shift registers and active code and span buffers
// [R16] Clear keeps holding buffers; later updates restore them
// [R17] Clear during an open frame aborts that frame
// [R18] Integrity flag low on power-up, clear, low supply until update
// [R19] 1110 puts the addressed channel(s) to sleep
// [R20] Pair inverter off only when both channels of the pair sleep
// [R21] Any update, load pin too, wakes the updated channels
// [R22] Span readback carries the sleep bit as fifth lowest bit
// [R23] Execute on select rising edge; frames under 24 bits ignored
// [R24] Outputs follow the active buffers only
`timescale 1ns/1ps
module qdac_core
   import qdac_pkg::*;
(
   // System clock and reset
   clock,
   sys_rst,
   // Serial link
   sclk,
   select_load_n,
   serial_in,
   readback_out,
   readback_oe,
   // Asynchronous control pins and supply monitor
   async_clear_n,
   async_load_n,
   supply_low,
   // Active code per channel
   dac_code_a,
   dac_code_b,
   dac_code_c,
   dac_code_d,
   // Active span per channel
   dac_span_a,
   dac_span_b,
   dac_span_c,
   dac_span_d,
   // Power state and status
   chan_sleep,
   ref_inv_on,
   integrity_flag_n
);
   input wire logic clock;
   input wire logic sys_rst;
   input wire logic sclk;
   input wire logic select_load_n;
   input wire logic serial_in;
   output logic readback_out;
   output logic readback_oe;
   input wire logic async_clear_n;
   input wire logic async_load_n;
   input wire logic supply_low;
   output logic [15:0] dac_code_a;
   output logic [15:0] dac_code_b;
   output logic [15:0] dac_code_c;
   output logic [15:0] dac_code_d;
   output logic [3:0] dac_span_a;
   output logic [3:0] dac_span_b;
   output logic [3:0] dac_span_c;
   output logic [3:0] dac_span_d;
   output logic [3:0] chan_sleep;
   output logic [1:0] ref_inv_on;
   output logic integrity_flag_n;

   // Buffers and control state
   logic [15:0] hold_code_ff [NCH];
   logic [3:0] hold_span_ff [NCH];
   logic [15:0] act_code_ff [NCH];
   logic [3:0] act_span_ff [NCH];
   logic [15:0] nxt_hold_code [NCH];
   logic [3:0] nxt_hold_span [NCH];
   logic [15:0] nxt_act_code [NCH];
   logic [3:0] nxt_act_span [NCH];
   logic [3:0] sleep_ff;
   logic [3:0] nxt_sleep;
   logic [1:0] inv_on_ff;
   logic cs_d_ff;
   logic ld_d_ff;
   logic abort_ff;
   logic nxt_abort;
   logic flag_n_ff;
   logic nxt_flag_n;
   logic oe_ff;
   qdac_rbsel_e ptr_sel_ff;
   qdac_rbsel_e nxt_ptr_sel;
   logic [1:0] ptr_ch_ff;
   logic [1:0] nxt_ptr_ch;

   // Synchronised pins
   logic [3:0] sync_q;
   logic cs_s;
   logic clr_s_n;
   logic ld_s_n;
   logic vlow_s;

   // Link side views
   logic [23:0] frame_bits;
   logic [5:0] frame_count;
   logic [63:0] hold_code_flat;
   logic [15:0] hold_span_flat;
   logic [63:0] act_code_flat;
   logic [15:0] act_span_flat;

   // Frame decode
   logic frame_end;
   logic frame_ok;
   logic [3:0] cmd;
   logic [3:0] addr;
   logic [15:0] data;
   logic addr_all;
   logic [1:0] ch;
   logic valid;
   logic is_wspan;
   logic is_wcode;
   logic is_upd_n;
   logic is_upd_all;
   logic is_sleep;
   logic is_read;
   logic ptr_aspan;
   logic span_ok;
   logic load_ev;
   logic any_upd;
   logic [3:0] wr_mask;
   logic [3:0] upd_mask;

   // Pins cross into the system clock through two flip-flops
   qdac_sync #(
      .W(4),
      .RST_VAL(4'he)
   ) u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .din({select_load_n, async_clear_n, async_load_n, supply_low}),
      .dout(sync_q)
   );
   assign cs_s = sync_q[3];
   assign clr_s_n = sync_q[2];
   assign ld_s_n = sync_q[1];
   assign vlow_s = sync_q[0];

   // Buffers flattened for the link; apart from a clear they only move while select is high
   genvar f;
   generate
      for (f = 0; f < NCH; f++) begin : g_flat
         assign hold_code_flat[f*16 +: 16] = hold_code_ff[f];
         assign hold_span_flat[f*4 +: 4] = hold_span_ff[f];
         assign act_code_flat[f*16 +: 16] = act_code_ff[f];
         assign act_span_flat[f*4 +: 4] = act_span_ff[f];
      end
   endgenerate

   // Link logic on the serial clock
   qdac_link u_link (
      .sclk(sclk),
      .select_load_n(select_load_n),
      .serial_in(serial_in),
      .async_clear_n(async_clear_n),
      .sys_rst(sys_rst),
      .hold_code(hold_code_flat),
      .hold_span(hold_span_flat),
      .act_code(act_code_flat),
      .act_span(act_span_flat),
      .sleep(sleep_ff),
      .ptr_sel(ptr_sel_ff),
      .ptr_ch(ptr_ch_ff),
      .frame_bits(frame_bits),
      .frame_count(frame_count),
      .readback_out(readback_out)
   );

   // [R23] Frame closes on select rising; short or aborted frames dropped
   assign frame_end = cs_s & ~cs_d_ff;
   assign frame_ok = frame_end & ~abort_ff & clr_s_n &
      (frame_count >= FRAME_BITS);

   // [R1] Last 24 bits: command, address, data
   assign cmd = frame_bits[23:20];
   assign addr = frame_bits[19:16];
   assign data = frame_bits[15:0];

   // [R11] Address decode
   assign addr_all = (addr == ADDR_ALL);
   assign ch = qdac_addr_ch(addr);

   // [R13] Reserved commands are ignored; reserved addresses too, except with 0101
   assign valid = frame_ok & (cmd >= CMD_WR_SPAN) &
      (qdac_addr_ok(addr) | (cmd == CMD_UPD_ALL));

   // Command classes
   assign is_wspan = (cmd == CMD_WR_SPAN) | (cmd == CMD_WU_SPAN_N) |
      (cmd == CMD_WU_SPAN_ALL);
   assign is_wcode = (cmd == CMD_WR_CODE) | (cmd == CMD_WU_CODE_N) |
      (cmd == CMD_WU_CODE_ALL);
   assign is_upd_n = (cmd == CMD_UPD_N) | (cmd == CMD_WU_SPAN_N) |
      (cmd == CMD_WU_CODE_N);
   assign is_upd_all = (cmd == CMD_UPD_ALL) | (cmd == CMD_WU_SPAN_ALL) |
      (cmd == CMD_WU_CODE_ALL);
   assign is_sleep = (cmd == CMD_SLEEP);
   assign is_read = qdac_is_read(cmd);

   // [R12] Only the six defined span codes are stored
   assign span_ok = (data[3:0] <= SPAN_OFS);

   // [R4] Load pin falling while select is high
   assign load_ev = ld_d_ff & ~ld_s_n & cs_s;
   assign any_upd = load_ev | (valid & (is_upd_n | is_upd_all));

   // Per channel write, update, clear and sleep
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         // [R11] Channel addressed directly or by all-channels
         assign wr_mask[g] = valid & (addr_all | (ch == 2'(g)));
         // [R6] [R7] Update of this channel by command or load pin
         assign upd_mask[g] = load_ev | (valid & is_upd_all) |
            (wr_mask[g] & is_upd_n);
         // [R5] Holding span write
         assign nxt_hold_span[g] = (wr_mask[g] & is_wspan & span_ok) ?
            data[3:0] : hold_span_ff[g];
         // [R5] Holding code write
         assign nxt_hold_code[g] = (wr_mask[g] & is_wcode) ?
            data : hold_code_ff[g];
         // [R15] [R16] Clear zeroes active only; [R7] update sees new write
         assign nxt_act_code[g] = !clr_s_n ? CODE_RST :
            upd_mask[g] ? nxt_hold_code[g] : act_code_ff[g];
         assign nxt_act_span[g] = !clr_s_n ? SPAN_RST :
            upd_mask[g] ? nxt_hold_span[g] : act_span_ff[g];
         // [R21] Update wakes; [R19] sleep command powers down
         assign nxt_sleep[g] = (upd_mask[g] & clr_s_n) ? 1'b0 :
            (wr_mask[g] & is_sleep) ? 1'b1 : sleep_ff[g];

         // [R14] Buffers come up zero, span 0000
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               hold_code_ff[g] <= CODE_RST;
               hold_span_ff[g] <= SPAN_RST;
               act_code_ff[g] <= CODE_RST;
               act_span_ff[g] <= SPAN_RST;
            end else begin
               hold_code_ff[g] <= nxt_hold_code[g];
               hold_span_ff[g] <= nxt_hold_span[g];
               // [R24] Active buffers move only on update or clear
               act_code_ff[g] <= nxt_act_code[g];
               act_span_ff[g] <= nxt_act_span[g];
            end
         end
      end
   endgenerate

   // [R10] Pointer kind left for the next frame
   assign ptr_aspan = (cmd == CMD_UPD_N) | (cmd == CMD_WU_SPAN_N) |
      (cmd == CMD_WU_SPAN_ALL) | is_sleep;
   assign nxt_ptr_sel = !valid ? ptr_sel_ff :
      (cmd == CMD_WR_SPAN) ? RB_HSPAN :
      (cmd == CMD_WR_CODE) ? RB_HCODE :
      is_read ? qdac_rd_sel(cmd) :
      ptr_aspan ? RB_ASPAN : RB_ACODE;
   // [R11] All-channels and update-all point at channel A
   assign nxt_ptr_ch = !valid ? ptr_ch_ff :
      (addr_all | (cmd == CMD_UPD_ALL)) ? 2'h0 : ch;

   // [R17] Clear inside an open frame marks it aborted
   assign nxt_abort = (!clr_s_n && !cs_s) ? 1'b1 :
      frame_end ? 1'b0 : abort_ff;

   // [R18] Flag asserts on clear or low supply; a valid update releases it
   assign nxt_flag_n = (!clr_s_n || vlow_s) ? 1'b0 :
      any_upd ? 1'b1 : flag_n_ff;

   // Sleep, pointer and flag registers
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sleep_ff <= '0;
         ptr_sel_ff <= RB_ASPAN;
         ptr_ch_ff <= 2'h0;
         flag_n_ff <= 1'b0;
      end else begin
         sleep_ff <= nxt_sleep;
         ptr_sel_ff <= nxt_ptr_sel;
         ptr_ch_ff <= nxt_ptr_ch;
         flag_n_ff <= nxt_flag_n;
      end
   end

   // Edge history, abort state and readback enable
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cs_d_ff <= 1'b1;
         ld_d_ff <= 1'b1;
         abort_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else begin
         cs_d_ff <= cs_s;
         ld_d_ff <= ld_s_n;
         abort_ff <= nxt_abort;
         oe_ff <= ~cs_s;
      end
   end

   // [R20] Pair inverter stays on unless both channels sleep
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         inv_on_ff <= 2'h3;
      end else begin
         inv_on_ff[0] <= ~(nxt_sleep[0] & nxt_sleep[1]);
         inv_on_ff[1] <= ~(nxt_sleep[2] & nxt_sleep[3]);
      end
   end

   // [R24] Outputs taken straight from the active buffers
   assign dac_code_a = act_code_ff[0];
   assign dac_code_b = act_code_ff[1];
   assign dac_code_c = act_code_ff[2];
   assign dac_code_d = act_code_ff[3];
   assign dac_span_a = act_span_ff[0];
   assign dac_span_b = act_span_ff[1];
   assign dac_span_c = act_span_ff[2];
   assign dac_span_d = act_span_ff[3];

   // Status outputs
   assign chan_sleep = sleep_ff;
   assign ref_inv_on = inv_on_ff;
   assign integrity_flag_n = flag_n_ff;
   assign readback_oe = oe_ff;
endmodule

// ===== test/qdac_core_assertions.sv
// Concurrent port checks of the quad DAC command core
`timescale 1ns/1ps
module qdac_core_chk (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Pins in
   input wire logic select_load_n,
   input wire logic async_clear_n,
   input wire logic async_load_n,
   input wire logic supply_low,
   // Outputs watched
   input wire logic readback_oe,
   input wire logic [15:0] dac_code_a,
   input wire logic [15:0] dac_code_b,
   input wire logic [15:0] dac_code_c,
   input wire logic [15:0] dac_code_d,
   input wire logic [3:0] dac_span_a,
   input wire logic [3:0] dac_span_b,
   input wire logic [3:0] dac_span_c,
   input wire logic [3:0] dac_span_d,
   input wire logic [3:0] chan_sleep,
   input wire logic [1:0] ref_inv_on,
   input wire logic integrity_flag_n
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   // All active words side by side
   wire logic [79:0] outs = {dac_code_a, dac_code_b, dac_code_c, dac_code_d,
      dac_span_a, dac_span_b, dac_span_c, dac_span_d};
   // Clear seen low long enough to pass the synchroniser
   sequence s_clr_held;
      !async_clear_n [*3];
   endsequence
   // Load pin falls while no frame is open and nothing blocks updates
   sequence s_load_req;
      select_load_n && async_clear_n && !supply_low && $fell(async_load_n);
   endsequence
   property p_inv_ab;
      ref_inv_on[0] == !(chan_sleep[0] && chan_sleep[1]);
   endproperty
   a_inv_ab: assert property (p_inv_ab)
      else $error("pair AB inverter");
   property p_inv_cd;
      ref_inv_on[1] == !(chan_sleep[2] && chan_sleep[3]);
   endproperty
   a_inv_cd: assert property (p_inv_cd)
      else $error("pair CD inverter");
   property p_clr_zero;
      s_clr_held |=> outs == 80'h0;
   endproperty
   a_clr_zero: assert property (p_clr_zero)
      else $error("clear not zero");
   property p_clr_flag;
      s_clr_held |=> !integrity_flag_n;
   endproperty
   a_clr_flag: assert property (p_clr_flag)
      else $error("flag after clear");
   property p_supply_flag;
      supply_low [*3] |=> !integrity_flag_n;
   endproperty
   a_supply_flag: assert property (p_supply_flag)
      else $error("supply flag");
   property p_oe_idle;
      (select_load_n [*5] |-> !readback_oe) and
         (!select_load_n [*5] |-> readback_oe);
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("readback enable");
   property p_hold_out;
      (!select_load_n && async_load_n && async_clear_n) [*5] |=> $stable(outs);
   endproperty
   a_hold_out: assert property (p_hold_out)
      else $error("output moved");
   property p_load_wake;
      s_load_req |-> ##[1:5] (chan_sleep == 4'h0 && integrity_flag_n);
   endproperty
   a_load_wake: assert property (p_load_wake)
      else $error("load no wake");
endmodule

// ===== test/qdac_host.sv
// Serial host model: frames commands and gathers readback bits
`timescale 1ns/1ps
module qdac_host (
   // Serial link to the core
   output logic sclk,
   output logic select_load_n,
   output logic serial_in,
   input wire logic readback_out
);
   // Link idle: clock parked, frame closed
   initial begin
      sclk = 1'b0;
      select_load_n = 1'b1;
      serial_in = 1'b0;
   end
   // Send nbits of word, gather the 16 readback bits
   task automatic xfer(input logic [31:0] word, input int nbits,
         output logic [15:0] rb);
      int off;
      off = (nbits == 32) ? 8 : 0;
      rb = 16'h0000;
      select_load_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         serial_in = word[nbits-1-i];
         #7.5;
         if (i >= off + 8 && i < off + 24) rb = {rb[14:0], readback_out};
         sclk = 1'b1;
         #7.5;
         sclk = 1'b0;
      end
      #7.5;
      select_load_n = 1'b1;
      // Released data line flips so a stale bit is never trusted
      serial_in = ~serial_in;
      #320;
   endtask
endmodule

// ===== test/testbench.sv
// Self-checking bench of the quad DAC command core
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
   num_errors++; $display("mismatch at %0t: got %0h exp %0h", $time, a, e); \
   end end
module testbench;
   logic clock, sys_rst, sclk, select_load_n, serial_in, readback_out;
   logic readback_oe, async_clear_n, async_load_n, supply_low;
   logic [15:0] dac_code_a, dac_code_b, dac_code_c, dac_code_d;
   logic [3:0] dac_span_a, dac_span_b, dac_span_c, dac_span_d;
   logic [3:0] chan_sleep, sleep_state_bit;
   logic [1:0] ref_inv_on;
   logic integrity_flag_n, flag;
   logic [15:0] hc[4], ac[4], rb, d;
   logic [3:0] hs[4], as[4], c;
   logic [3:0] addrs[5] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'hf};
   int psel, pch, num_errors, comparisons, seed;
   wire logic [63:0] dcodes = {dac_code_d, dac_code_c, dac_code_b, dac_code_a};
   wire logic [15:0] dspans = {dac_span_d, dac_span_c, dac_span_b, dac_span_a};
   qdac_core DUT (.clock, .sys_rst, .sclk, .select_load_n, .serial_in,
      .readback_out, .readback_oe, .async_clear_n, .async_load_n, .supply_low,
      .dac_code_a, .dac_code_b, .dac_code_c, .dac_code_d, .dac_span_a,
      .dac_span_b, .dac_span_c, .dac_span_d, .chan_sleep, .ref_inv_on,
      .integrity_flag_n);
   qdac_host host (.sclk, .select_load_n, .serial_in, .readback_out);
   // System clock
   initial clock = 1'b0;
   always #20 clock = ~clock;
   // Readback word: 0 active span, 1 active code, 2 holding span, 3 code
   function automatic logic [15:0] rbval(input int s, input int ch);
      case (s)
         0: return {11'h000, sleep_state_bit[ch], as[ch]};
         1: return ac[ch];
         2: return {11'h000, sleep_state_bit[ch], hs[ch]};
         default: return hc[ch];
      endcase
   endfunction
   task automatic upd(input logic [3:0] m);
      for (int k = 0; k < 4; k++) if (m[k]) begin
         ac[k] = hc[k];
         as[k] = hs[k];
         sleep_state_bit[k] = 1'b0;
      end
      flag = 1'b1;
   endtask
   task automatic outs_chk();
      for (int k = 0; k < 4; k++) begin
         `CHK(dcodes[k*16 +: 16], ac[k])
         `CHK(dspans[k*4 +: 4], as[k])
      end
      `CHK(chan_sleep, sleep_state_bit)
      `CHK(ref_inv_on, {~&sleep_state_bit[3:2], ~&sleep_state_bit[1:0]})
      `CHK(integrity_flag_n, flag)
   endtask
   // One framed command: readback compared, model advanced, outputs checked
   task automatic cmd(input logic [3:0] c, input logic [3:0] a,
         input logic [15:0] d, input bit wide);
      logic [3:0] m;
      int ch;
      ch = (a == 4'hf) ? 0 : a[2:1];
      m = (a == 4'hf) ? 4'hf : 4'h1 << ch;
      @(negedge clock);
      host.xfer({8'h00, c, a, d}, wide ? 32 : 24, rb);
      @(negedge clock);
      if (c >= 4'ha && c <= 4'hd) begin
         `CHK(rb, rbval(c[1:0], ch))
         psel = c[1:0];
         pch = ch;
      end else begin
         `CHK(rb, rbval(psel, pch))
         for (int k = 0; k < 4; k++) if (m[k]) begin
            if (c inside {4'h2, 4'h6, 4'h8}) hs[k] = d[3:0];
            if (c inside {4'h3, 4'h7, 4'h9}) hc[k] = d;
         end
         if (c inside {4'h4, 4'h6, 4'h7}) upd(m);
         if (c inside {4'h5, 4'h8, 4'h9}) upd(4'hf);
         if (c == 4'he) sleep_state_bit = sleep_state_bit | m;
         psel = (c == 4'h2) ? 2 : (c == 4'h3) ? 3 :
            (c inside {4'h4, 4'h6, 4'h8, 4'he}) ? 0 : 1;
         pch = (c == 4'h5) ? 0 : ch;
      end
      outs_chk();
   endtask
   task automatic complete_run();
      $display("%0d comparisons, %0d mismatches", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      #300000;
      num_errors++;
      complete_run();
   end
   initial begin
      num_errors = 0;
      comparisons = 0;
      sys_rst = 1'b1;
      async_clear_n = 1'b1;
      async_load_n = 1'b1;
      supply_low = 1'b0;
      for (int k = 0; k < 4; k++) begin
         hc[k] = 16'h0000;
         ac[k] = 16'h0000;
         hs[k] = 4'h0;
         as[k] = 4'h0;
      end
      sleep_state_bit = 4'h0;
      flag = 1'b0;
      psel = 0;
      pch = 0;
      seed = $urandom(3319);
      repeat (3) @(posedge clock);
      @(negedge clock) sys_rst = 1'b0;
      repeat (3) @(negedge clock);
      outs_chk();
      $display("test reset done");
      // Every command once, then random defined codes only
      for (int i = 0; i < 60; i++) begin
         c = (i < 14) ? 4'(i + 2) : 4'($urandom_range(15, 2));
         d = 16'($urandom);
         if (c inside {4'h2, 4'h6, 4'h8}) d[3:0] = 4'($urandom_range(5));
         cmd(c, addrs[$urandom_range(4)], d, 1'($urandom));
      end
      for (int s = 0; s < 6; s++) cmd(4'h6, 4'h6, 16'(s), 1'b0);
      $display("test commands done");
      // Short frame is dropped
      @(negedge clock);
      host.xfer({8'h00, 4'h7, 4'h0, 16'h1234}, 20, rb);
      outs_chk();
      // Low supply holds the flag until an update
      @(negedge clock) supply_low = 1'b1;
      repeat (4) @(negedge clock);
      supply_low = 1'b0;
      flag = 1'b0;
      repeat (4) @(negedge clock);
      outs_chk();
      cmd(4'h4, 4'hf, 16'h0000, 1'b1);
      $display("test short frame and supply done");
      // Clear zeroes the active side; load pin restores holding
      cmd(4'he, 4'hf, 16'h0000, 1'b0);
      async_clear_n = 1'b0;
      repeat (5) @(negedge clock);
      for (int k = 0; k < 4; k++) ac[k] = 16'h0000;
      for (int k = 0; k < 4; k++) as[k] = 4'h0;
      flag = 1'b0;
      outs_chk();
      async_clear_n = 1'b1;
      repeat (4) @(negedge clock);
      async_load_n = 1'b0;
      repeat (3) @(negedge clock);
      async_load_n = 1'b1;
      repeat (3) @(negedge clock);
      upd(4'hf);
      outs_chk();
      // Clear inside an open frame aborts it
      @(negedge clock);
      fork
         host.xfer({8'h00, 4'h9, 4'hf, 16'hbeef}, 24, rb);
         begin
            repeat (5) @(negedge clock);
            async_clear_n = 1'b0;
         end
      join
      @(negedge clock) async_clear_n = 1'b1;
      repeat (4) @(negedge clock);
      for (int k = 0; k < 4; k++) ac[k] = 16'h0000;
      for (int k = 0; k < 4; k++) as[k] = 4'h0;
      flag = 1'b0;
      outs_chk();
      cmd(4'hb, 4'h0, 16'h0000, 1'b0);
      cmd(4'h5, 4'hf, 16'h0000, 1'b0);
      $display("test clear and load done");
      complete_run();
   end
endmodule
bind qdac_core qdac_core_chk chk (.clock, .sys_rst, .select_load_n,
   .async_clear_n, .async_load_n, .supply_low, .readback_oe, .dac_code_a,
   .dac_code_b, .dac_code_c, .dac_code_d, .dac_span_a, .dac_span_b,
   .dac_span_c, .dac_span_d, .chan_sleep, .ref_inv_on, .integrity_flag_n);
